// ===== src/isr_pkg.sv
// Package for the I2C slave response control block: register map,
// field positions, reset values and the serial engine state encoding.
// Assumes a 32-bit Avalon-MM register bus with byte addresses.
package isr_pkg;

   // Register bus geometry
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 32;

   // Register byte offsets
   localparam logic [7:0] OFF_ENABLE = 8'h00;
   localparam logic [7:0] OFF_STATUS = 8'h04;
   localparam logic [7:0] OFF_OWN_ADDR = 8'h08;
   localparam logic [7:0] OFF_TX_DATA = 8'h0C;
   localparam logic [7:0] OFF_RX_DATA = 8'h10;
   localparam logic [7:0] OFF_SLAVE_DATA_REFUSE = 8'h84;
   localparam logic [7:0] OFF_DATA_SETUP_DELAY = 8'h94;
   localparam logic [7:0] OFF_BROADCAST_ACK_CONTROL = 8'h98;

   // Field positions
   localparam int unsigned POS_ENABLE = 0;
   localparam int unsigned POS_REFUSE_DATA_BIT = 0;
   localparam int unsigned POS_BROADCAST_ACK_FLAG = 0;
   localparam int unsigned POS_STAT_ACTIVE = 0;
   localparam int unsigned POS_STAT_BCAST_SEEN = 1;
   localparam int unsigned POS_STAT_RX_FULL = 2;

   // Values after reset
   localparam logic RST_ENABLE = 1'b0;
   localparam logic RST_REFUSE = 1'b0;
   localparam logic RST_BCAST = 1'b0;
   localparam logic [7:0] RST_SETUP = 8'h00;
   localparam logic [6:0] RST_OWN_ADDR = 7'h10;
   localparam logic [7:0] RST_TX_DATA = 8'h00;

   // Serial protocol constants
   localparam logic [7:0] BROADCAST_ADDR_BYTE = 8'h00;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;

   // Serial engine states
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_ADDR = 3'b001,
      ST_ACK = 3'b010,
      ST_RX = 3'b011,
      ST_TX = 3'b100,
      ST_TXACK = 3'b101,
      ST_WAIT = 3'b110
   } isr_state_e;

endpackage

// ===== src/isr_slave_resp.sv
// I2C slave response control: register file on Avalon-MM plus a slave
// serial engine (address, receive with forced refusal, transmit with
// data setup stretch, broadcast address answer).
// Assumes open-drain pins resolved outside; link_clk is the engine clock.
//
// Summary of operation
// - Refusal register exists only with build option
// - Refusal write needs disabled and slave idle
// - Refusal set: NACK data, drop byte
// - Refusal clear: normal acknowledge of data
// - Transmit: hold clock low for setup count
// - Setup register writable only while disabled
// - One bit chooses broadcast address answer
// - Bit set ACKs broadcast; clear, no event
`timescale 1ns/10ps
`default_nettype none

module isr_slave_resp #(
   parameter bit SLAVE_REFUSE_BUILD_OPTION = 1'b1
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic clk_en,
   input wire logic [isr_pkg::ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [isr_pkg::DATA_W-1:0] avs_writedata,
   output logic [isr_pkg::DATA_W-1:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic link_clk,
   input wire logic scl_i,
   output logic scl_o,
   output logic scl_oe_n,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_n
);
   import isr_pkg::*;

   localparam int unsigned CFG_W = 27;

   // Register select helper, shared by the write and read-clear decodes below; the read mux decodes by case
   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
      hit = (a == off);
   endfunction

   // ------------------------------------------------------------------
   // Reference clock domain: bus slave and registers
   // ------------------------------------------------------------------
   logic ack_q;
   logic req;
   logic wr_fire;
   logic rd_fire;
   logic rd_first;
   logic enable_q;
   logic refuse_q;
   logic bcast_q;
   logic [7:0] setup_q;
   logic [6:0] own_addr_q;
   logic [7:0] tx_data_q;
   logic [7:0] rx_data_q;
   logic rx_full_q;
   logic bcast_seen_q;
   logic [1:0] active_sync_q;
   logic [2:0] rx_tog_sync_q;
   logic [2:0] bc_tog_sync_q;
   logic active_s;
   logic rx_event;
   logic bc_event;
   logic [DATA_W-1:0] rd_mux;
   // Engine outputs read across the domain boundary
   logic eng_active_q;
   logic rx_tog_q;
   logic bc_tog_q;
   logic [7:0] rx_byte_q;

   // One wait cycle per access keeps the read mux off the bus path
   assign req = avs_read | avs_write;
   assign avs_waitrequest = req & ~(ack_q & clk_en);
   assign wr_fire = avs_write & ack_q & clk_en;
   assign rd_fire = avs_read & ack_q & clk_en;
   assign rd_first = avs_read & ~ack_q & clk_en;

   always_ff @(posedge ref_clk)
   begin
      if (rst)
         ack_q <= 1'b0;
      else if (clk_en)
         ack_q <= req & ~ack_q;
   end

   // Engine status crossing back: levels through two flops, toggles
   // through two flops plus a third for edge detection
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         active_sync_q <= 2'b00;
         rx_tog_sync_q <= 3'b000;
         bc_tog_sync_q <= 3'b000;
      end
      else if (clk_en)
      begin
         active_sync_q <= {active_sync_q[0], eng_active_q};
         rx_tog_sync_q <= {rx_tog_sync_q[1:0], rx_tog_q};
         bc_tog_sync_q <= {bc_tog_sync_q[1:0], bc_tog_q};
      end
   end

   assign active_s = active_sync_q[1];
   assign rx_event = clk_en & (rx_tog_sync_q[2] ^ rx_tog_sync_q[1]);
   assign bc_event = clk_en & (bc_tog_sync_q[2] ^ bc_tog_sync_q[1]);

   // Control registers written by software
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         enable_q <= RST_ENABLE;
         own_addr_q <= RST_OWN_ADDR;
         tx_data_q <= RST_TX_DATA;
         bcast_q <= RST_BCAST;
      end
      else if (wr_fire)
      begin
         if (hit(avs_address, OFF_ENABLE))
            enable_q <= avs_writedata[POS_ENABLE];
         // Address changes mid-transfer would corrupt matching
         if (hit(avs_address, OFF_OWN_ADDR) && !enable_q)
            own_addr_q <= avs_writedata[6:0];
         if (hit(avs_address, OFF_TX_DATA))
            tx_data_q <= avs_writedata[7:0];
         if (hit(avs_address, OFF_BROADCAST_ACK_CONTROL))
            bcast_q <= avs_writedata[POS_BROADCAST_ACK_FLAG];
      end
   end

   // Refusal bit: absent without the build option, guarded otherwise
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         refuse_q <= RST_REFUSE;
      else if (wr_fire && hit(avs_address, OFF_SLAVE_DATA_REFUSE)
               && SLAVE_REFUSE_BUILD_OPTION
               && !enable_q && !active_s)
         refuse_q <= avs_writedata[POS_REFUSE_DATA_BIT];
   end

   // Setup delay: writes made while enabled are discarded
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         setup_q <= RST_SETUP;
      else if (wr_fire && hit(avs_address, OFF_DATA_SETUP_DELAY) && !enable_q)
         setup_q <= avs_writedata[7:0];
   end

   // Received byte and full flag; a new byte wins over the clearing read
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         rx_data_q <= 8'h00;
         rx_full_q <= 1'b0;
      end
      else if (rx_event)
      begin
         rx_data_q <= rx_byte_q;
         rx_full_q <= 1'b1;
      end
      else if (rd_fire && hit(avs_address, OFF_RX_DATA))
         rx_full_q <= 1'b0;
   end

   // Broadcast seen flag, write one to clear; a new event wins
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         bcast_seen_q <= 1'b0;
      else if (bc_event)
         bcast_seen_q <= 1'b1;
      else if (wr_fire && hit(avs_address, OFF_STATUS) && avs_writedata[POS_STAT_BCAST_SEEN])
         bcast_seen_q <= 1'b0;
   end

   // Read mux; unused and reserved bits are zero
   always_comb
   begin
      rd_mux = '0;
      case (avs_address)
         OFF_ENABLE: rd_mux[POS_ENABLE] = enable_q;
         OFF_STATUS:
         begin
            rd_mux[POS_STAT_ACTIVE] = active_s;
            rd_mux[POS_STAT_BCAST_SEEN] = bcast_seen_q;
            rd_mux[POS_STAT_RX_FULL] = rx_full_q;
         end
         OFF_OWN_ADDR: rd_mux[6:0] = own_addr_q;
         OFF_TX_DATA: rd_mux[7:0] = tx_data_q;
         OFF_RX_DATA: rd_mux[7:0] = rx_data_q;
         OFF_SLAVE_DATA_REFUSE: rd_mux[POS_REFUSE_DATA_BIT] = refuse_q;
         OFF_DATA_SETUP_DELAY: rd_mux[7:0] = setup_q;
         OFF_BROADCAST_ACK_CONTROL: rd_mux[POS_BROADCAST_ACK_FLAG] = bcast_q;
         default: rd_mux = '0;
      endcase
   end

   // Read data latched in the wait cycle, stable at the completing edge
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         avs_readdata <= '0;
      else if (rd_first)
         avs_readdata <= rd_mux;
   end

   // ------------------------------------------------------------------
   // Link clock domain: serial engine
   // ------------------------------------------------------------------
   logic [CFG_W-1:0] cfg_meta_q;
   logic [CFG_W-1:0] cfg_q;
   logic [1:0] rst_sync_q;
   logic [2:0] scl_sync_q;
   logic [2:0] sda_sync_q;
   logic l_rst;
   logic l_en;
   logic l_enable;
   logic l_refuse;
   logic l_bcast;
   logic [7:0] l_setup;
   logic [6:0] l_own_addr;
   logic [7:0] l_tx_data;
   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;
   logic sda_s;
   isr_state_e state_q;
   isr_state_e next_q;
   logic [7:0] shift_q;
   logic [3:0] cnt_q;
   logic [7:0] stretch_q;
   logic data_line_output_drive_q;

   // Configuration is quasi-static: setup, refusal and own address change only while disabled
   always_ff @(posedge link_clk)
   begin
      cfg_meta_q <= {clk_en, enable_q, refuse_q, bcast_q, setup_q, own_addr_q, tx_data_q};
      cfg_q <= cfg_meta_q;
      rst_sync_q <= {rst_sync_q[0], rst};
   end

   assign l_rst = rst_sync_q[1];
   assign {l_en, l_enable, l_refuse, l_bcast, l_setup, l_own_addr, l_tx_data} = cfg_q;

   // Bus pins: two flops, third stage only for edge detection
   always_ff @(posedge link_clk)
   begin
      if (l_rst)
      begin
         scl_sync_q <= 3'b111;
         sda_sync_q <= 3'b111;
      end
      else if (l_en)
      begin
         scl_sync_q <= {scl_sync_q[1:0], scl_i};
         sda_sync_q <= {sda_sync_q[1:0], sda_i};
      end
   end

   assign sda_s = sda_sync_q[1];
   assign scl_rise = l_en & scl_sync_q[1] & ~scl_sync_q[2];
   assign scl_fall = l_en & ~scl_sync_q[1] & scl_sync_q[2];
   assign start_det = l_en & scl_sync_q[1] & scl_sync_q[2] & ~sda_sync_q[1] & sda_sync_q[2];
   assign stop_det = l_en & scl_sync_q[1] & scl_sync_q[2] & sda_sync_q[1] & ~sda_sync_q[2];

   // Open-drain outputs only ever pull low
   assign scl_o = 1'b0;
   assign sda_o = 1'b0;
   assign sda_oe_n = ~data_line_output_drive_q;
   assign scl_oe_n = (stretch_q == 8'h00);

   // Slave protocol engine
   always_ff @(posedge link_clk)
   begin
      if (l_rst)
      begin
         state_q <= ST_IDLE;
         next_q <= ST_IDLE;
         shift_q <= 8'h00;
         cnt_q <= 4'h0;
         stretch_q <= 8'h00;
         data_line_output_drive_q <= 1'b0;
         rx_tog_q <= 1'b0;
         bc_tog_q <= 1'b0;
         rx_byte_q <= 8'h00;
      end
      else if (l_en)
      begin
         if (stretch_q != 8'h00)
            stretch_q <= stretch_q - 8'h01;
         if (!l_enable || stop_det)
         begin
            state_q <= ST_IDLE;
            data_line_output_drive_q <= 1'b0;
            stretch_q <= 8'h00;
         end
         else if (start_det)
         begin
            // Repeated start lands here as well
            state_q <= ST_ADDR;
            cnt_q <= 4'h0;
            data_line_output_drive_q <= 1'b0;
         end
         else
         begin
            case (state_q)
               ST_ADDR, ST_RX:
               begin
                  if (scl_rise)
                  begin
                     shift_q <= {shift_q[6:0], sda_s};
                     cnt_q <= cnt_q + 4'h1;
                  end
                  else if (scl_fall && cnt_q == BITS_PER_BYTE)
                  begin
                     if (state_q == ST_RX)
                     begin
                        if (l_refuse)
                           state_q <= ST_WAIT;
                        else
                        begin
                           // Every data byte is taken; overrun overwrites
                           data_line_output_drive_q <= 1'b1;
                           rx_byte_q <= shift_q;
                           rx_tog_q <= ~rx_tog_q;
                           next_q <= ST_RX;
                           state_q <= ST_ACK;
                        end
                     end
                     else if (shift_q == BROADCAST_ADDR_BYTE)
                     begin
                        if (l_bcast)
                        begin
                           data_line_output_drive_q <= 1'b1;
                           bc_tog_q <= ~bc_tog_q;
                           next_q <= ST_RX;
                           state_q <= ST_ACK;
                        end
                        else
                           state_q <= ST_WAIT;
                     end
                     else if (shift_q[7:1] == l_own_addr)
                     begin
                        data_line_output_drive_q <= 1'b1;
                        next_q <= shift_q[0] ? ST_TX : ST_RX;
                        state_q <= ST_ACK;
                     end
                     else
                        state_q <= ST_WAIT;
                  end
               end
               ST_ACK:
               begin
                  if (scl_fall)
                  begin
                     cnt_q <= 4'h0;
                     state_q <= next_q;
                     if (next_q == ST_TX)
                     begin
                        // First bit out, then hold the clock low
                        shift_q <= {l_tx_data[6:0], 1'b0};
                        data_line_output_drive_q <= ~l_tx_data[7];
                        stretch_q <= l_setup;
                     end
                     else
                        data_line_output_drive_q <= 1'b0;
                  end
               end
               ST_TX:
               begin
                  if (scl_rise)
                     cnt_q <= cnt_q + 4'h1;
                  else if (scl_fall)
                  begin
                     if (cnt_q == BITS_PER_BYTE)
                     begin
                        data_line_output_drive_q <= 1'b0;
                        state_q <= ST_TXACK;
                     end
                     else
                     begin
                        data_line_output_drive_q <= ~shift_q[7];
                        shift_q <= {shift_q[6:0], 1'b0};
                        stretch_q <= l_setup;
                     end
                  end
               end
               ST_TXACK:
               begin
                  // Master refusal ends our transmit; its ACK asks for more
                  if (scl_rise && sda_s)
                     state_q <= ST_WAIT;
                  else if (scl_fall)
                  begin
                     cnt_q <= 4'h0;
                     shift_q <= {l_tx_data[6:0], 1'b0};
                     data_line_output_drive_q <= ~l_tx_data[7];
                     stretch_q <= l_setup;
                     state_q <= ST_TX;
                  end
               end
               ST_WAIT:
                  data_line_output_drive_q <= 1'b0;
               default:
                  state_q <= ST_IDLE;
            endcase
         end
      end
   end

   // Slave activity, sent back to the register side as a level
   always_ff @(posedge link_clk)
   begin
      if (l_rst)
         eng_active_q <= 1'b0;
      else if (l_en)
         eng_active_q <= (state_q != ST_IDLE) && (state_q != ST_WAIT);
   end

endmodule // isr_slave_resp

`default_nettype wire

// ===== verif/isr_master.sv
// Remote bus master model driving both open-drain lines (1 = released).
// Assumes the bench resolves each line from all drivers with a pull-up.
`timescale 1ns/10ps
`default_nettype none
module isr_master (
   input wire logic scl_i,
   input wire logic sda_i,
   output logic scl_m,
   output logic sda_m
);
   logic stuck = 1'b0;
   initial
   begin
      scl_m = 1'b1;
      sda_m = 1'b1;
   end
   // One clock pulse; the wait on a held clock is bounded
   task automatic pulse(output logic s);
      #300 scl_m = 1'b1;
      for (int k = 0; k < 300 && scl_i !== 1'b1; k++)
         #10;
      stuck |= (scl_i !== 1'b1);
      #1000 s = sda_i;
      scl_m = 1'b0;
      #300;
   endtask
   task automatic start();
      sda_m = 1'b1;
      #300 scl_m = 1'b1;
      #700 sda_m = 1'b0;
      #700 scl_m = 1'b0;
      #300;
   endtask
   task automatic stop();
      sda_m = 1'b0;
      #300 scl_m = 1'b1;
      #700 sda_m = 1'b1;
      #700;
   endtask
   // Byte out MSB first; ninth pulse gives the slave's answer
   task automatic send(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--)
      begin
         sda_m = b[i];
         pulse(s);
      end
      sda_m = 1'b1;
      pulse(s);
      ack = !s;
   endtask
   task automatic recv(input logic ack, output logic [7:0] b);
      logic s;
      sda_m = 1'b1;
      for (int i = 7; i >= 0; i--)
         pulse(b[i]);
      sda_m = !ack;
      pulse(s);
   endtask
endmodule // isr_master
`default_nettype wire

// ===== verif/isr_slave_resp_checker.sv
// Checker for the slave response block: bus answer, settings, clock stretch.
// Assumes it is bound to every instance; settings change only by bus writes.
`timescale 1ns/10ps
`default_nettype none
module isr_slave_resp_checker
   import isr_pkg::*;
#(
   parameter bit SLAVE_REFUSE_BUILD_OPTION = 1'b1
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic clk_en,
   input wire logic link_clk,
   input wire logic [isr_pkg::ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [isr_pkg::DATA_W-1:0] avs_writedata,
   input wire logic [isr_pkg::DATA_W-1:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic scl_oe_n
);
   logic en_q, refuse_q, bcast_q, wr_ok, rd_ok;
   logic [7:0] setup_q, low_q;
   assign wr_ok = avs_write && !avs_waitrequest;
   assign rd_ok = avs_read && !avs_waitrequest;
   // Shadow settings; locked fields follow the enable shadow
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         en_q <= 1'b0;
         refuse_q <= 1'b0;
         bcast_q <= 1'b0;
         setup_q <= 8'h00;
      end
      else if (wr_ok)
      begin
         if (avs_address == OFF_ENABLE)
            en_q <= avs_writedata[0];
         if (avs_address == OFF_BROADCAST_ACK_CONTROL)
            bcast_q <= avs_writedata[0];
         if (avs_address == OFF_DATA_SETUP_DELAY && !en_q)
            setup_q <= avs_writedata[7:0];
         if (avs_address == OFF_SLAVE_DATA_REFUSE && !en_q && SLAVE_REFUSE_BUILD_OPTION)
            refuse_q <= avs_writedata[0];
      end
   end
   // Length of the present clock hold, in link cycles
   always_ff @(posedge link_clk)
   begin
      if (rst || scl_oe_n)
         low_q <= 8'h00;
      else
         low_q <= low_q + 8'h01;
   end
   // One wait cycle while running; a frozen clock enable stretches it
   property p_wait_one;
      @(posedge ref_clk) disable iff (rst)
         $rose(avs_read || avs_write) && clk_en |-> avs_waitrequest ##1 (!avs_waitrequest || !clk_en);
   endproperty
   a_wait_one: assert property (p_wait_one) else $error("wait state count wrong");
   property p_freeze_wait;
      @(posedge ref_clk) disable iff (rst) (avs_read || avs_write) && !clk_en |-> avs_waitrequest;
   endproperty
   a_freeze_wait: assert property (p_freeze_wait) else $error("answer while frozen");
   property p_wait_idle; @(posedge ref_clk) disable iff (rst) !(avs_read || avs_write) |-> !avs_waitrequest; endproperty
   a_wait_idle: assert property (p_wait_idle) else $error("wait without request");
   property p_rdata_hold; @(posedge ref_clk) disable iff (rst) !avs_read |=> $stable(avs_readdata); endproperty
   a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
   property p_rd_refuse; @(posedge ref_clk) disable iff (rst) rd_ok && avs_address == OFF_SLAVE_DATA_REFUSE |-> avs_readdata == {31'h0, refuse_q}; endproperty
   a_rd_refuse: assert property (p_rd_refuse) else $error("refusal register wrong");
   property p_rd_setup; @(posedge ref_clk) disable iff (rst) rd_ok && avs_address == OFF_DATA_SETUP_DELAY |-> avs_readdata == {24'h0, setup_q}; endproperty
   a_rd_setup: assert property (p_rd_setup) else $error("setup register wrong");
   property p_rd_bcast; @(posedge ref_clk) disable iff (rst) rd_ok && avs_address == OFF_BROADCAST_ACK_CONTROL |-> avs_readdata == {31'h0, bcast_q}; endproperty
   a_rd_bcast: assert property (p_rd_bcast) else $error("broadcast register wrong");
   property p_hold_len; @(posedge link_clk) disable iff (rst) $rose(scl_oe_n) |-> low_q == setup_q; endproperty
   a_hold_len: assert property (p_hold_len) else $error("clock hold length wrong");
   property p_no_hold; @(posedge link_clk) disable iff (rst) setup_q == 8'h00 |-> scl_oe_n; endproperty
   a_no_hold: assert property (p_no_hold) else $error("clock held with zero setup");
   c_hold: cover property (@(posedge link_clk) disable iff (rst) $rose(scl_oe_n));
   c_refuse_rd: cover property (@(posedge ref_clk) disable iff (rst) rd_ok && avs_address == OFF_SLAVE_DATA_REFUSE);
   c_locked_wr: cover property (@(posedge ref_clk) disable iff (rst) wr_ok && en_q && avs_address == OFF_DATA_SETUP_DELAY);
endmodule // isr_slave_resp_checker
bind isr_slave_resp isr_slave_resp_checker #(.SLAVE_REFUSE_BUILD_OPTION(SLAVE_REFUSE_BUILD_OPTION)) i_chk (
   .ref_clk(ref_clk), .rst(rst), .link_clk(link_clk), .avs_address(avs_address), .avs_read(avs_read),
   .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .scl_oe_n(scl_oe_n), .clk_en(clk_en));
`default_nettype wire

// ===== verif/testbench.sv
// Testbench: register bus tasks plus remote master traffic on the link.
// Assumes own address reset value; second instance has no refusal register.
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import isr_pkg::*;
   localparam logic [31:0] ALL = 32'hFFFFFFFF;
   logic ref_clk = 1'b0;
   logic link_clk = 1'b0;
   logic rst = 1'b1;
   logic clk_en = 1'b1;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [7:0] avs_address = 8'h00;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata, readdata_b, rd;
   logic avs_waitrequest, scl_o, scl_oe_n, sda_o, sda_oe_n, scl_m, sda_m, scl_w, sda_w, ack;
   logic [7:0] b;
   int errors = 0;
   int n_compared = 0;
   always #50 ref_clk = !ref_clk;
   // Link clock offset so its phase is unrelated
   initial
   begin
      #17;
      forever #40 link_clk = !link_clk;
   end
   // Lines are low when any party pulls
   assign scl_w = scl_m & (scl_oe_n | scl_o);
   assign sda_w = sda_m & (sda_oe_n | sda_o);
   isr_slave_resp i_isr_slave_resp (.ref_clk(ref_clk), .rst(rst), .clk_en(clk_en), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .link_clk(link_clk), .scl_i(scl_w), .scl_o(scl_o), .scl_oe_n(scl_oe_n),
      .sda_i(sda_w), .sda_o(sda_o), .sda_oe_n(sda_oe_n));
   isr_slave_resp #(.SLAVE_REFUSE_BUILD_OPTION(1'b0)) i_isr_slave_resp_nb (.ref_clk(ref_clk), .rst(rst),
      .clk_en(clk_en), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(readdata_b), .avs_waitrequest(), .link_clk(link_clk),
      .scl_i(1'b1), .scl_o(), .scl_oe_n(), .sda_i(1'b1), .sda_o(), .sda_oe_n());
   isr_master i_isr_master (.scl_i(scl_w), .sda_i(sda_w), .scl_m(scl_m), .sda_m(sda_m));
   task automatic finish_test();
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_compared++;
      if (got !== exp)
      begin
         errors++;
         $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   // One transfer; request held until waitrequest is seen low
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge ref_clk);
      avs_address <= a;
      avs_writedata <= wd;
      avs_write <= wr;
      avs_read <= !wr;
      for (int k = 0; k <= 20; k++)
      begin
         @(posedge ref_clk);
         if (avs_waitrequest === 1'b0)
            break;
         if (k == 20)
         begin
            errors++;
            finish_test();
         end
      end
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp, input string what);
      bus(1'b0, a, 32'h0);
      check(rd & m, exp, what);
   endtask
   // Addressed transfer; a data byte follows only when the address is expected to be accepted
   task automatic xfer(input logic [7:0] a, input logic ea, input logic [7:0] d, input logic ed, input string what);
      i_isr_master.start();
      i_isr_master.send(a, ack);
      check({31'h0, ack}, {31'h0, ea}, what);
      if (ea)
      begin
         i_isr_master.send(d, ack);
         check({31'h0, ack}, {31'h0, ed}, what);
      end
      i_isr_master.stop();
   endtask
   task automatic t_regs();
      rdchk(OFF_SLAVE_DATA_REFUSE, ALL, 32'h0, "refuse reset");
      rdchk(OFF_DATA_SETUP_DELAY, ALL, 32'h0, "setup reset");
      rdchk(OFF_BROADCAST_ACK_CONTROL, ALL, 32'h0, "bcast reset");
      bus(1'b1, OFF_SLAVE_DATA_REFUSE, ALL);
      rdchk(OFF_SLAVE_DATA_REFUSE, ALL, 32'h1, "refuse set");
      check(readdata_b, 32'h0, "no option");
      bus(1'b1, OFF_DATA_SETUP_DELAY, 32'hFFFFFF0A);
      rdchk(OFF_DATA_SETUP_DELAY, ALL, 32'h0000000A, "setup set");
      bus(1'b1, 8'h40, ALL);
      rdchk(8'h40, ALL, 32'h0, "unmapped");
      bus(1'b1, OFF_ENABLE, 32'h1);
      bus(1'b1, OFF_DATA_SETUP_DELAY, 32'h3);
      rdchk(OFF_DATA_SETUP_DELAY, ALL, 32'h0000000A, "setup locked");
      bus(1'b1, OFF_SLAVE_DATA_REFUSE, 32'h0);
      rdchk(OFF_SLAVE_DATA_REFUSE, ALL, 32'h1, "refuse locked");
      $display("test regs done");
   endtask
   // Clock enable low holds the bus answer back until it returns
   task automatic t_freeze();
      fork
         bus(1'b1, OFF_TX_DATA, 32'h5C);
         begin
            @(posedge ref_clk);
            clk_en <= 1'b0;
            repeat (4) @(posedge ref_clk) check({31'h0, avs_waitrequest}, 32'h1, "frozen wait");
            clk_en <= 1'b1;
         end
      join
      rdchk(OFF_TX_DATA, 32'hFF, 32'h5C, "after freeze");
      $display("test freeze done");
   endtask
   task automatic t_rx();
      xfer(8'h20, 1'b1, 8'h5A, 1'b0, "data refused");
      rdchk(OFF_STATUS, 32'h4, 32'h0, "nothing stored");
      bus(1'b1, OFF_ENABLE, 32'h0);
      bus(1'b1, OFF_SLAVE_DATA_REFUSE, 32'h0);
      rdchk(OFF_SLAVE_DATA_REFUSE, ALL, 32'h0, "refuse cleared");
      bus(1'b1, OFF_ENABLE, 32'h1);
      xfer(8'h20, 1'b1, 8'hC3, 1'b1, "data taken");
      rdchk(OFF_RX_DATA, 32'hFF, 32'hC3, "byte stored");
      $display("test rx done");
   endtask
   task automatic t_tx();
      bus(1'b1, OFF_TX_DATA, 32'hA5);
      i_isr_master.start();
      i_isr_master.send(8'h21, ack);
      check({31'h0, ack}, 32'h1, "read address");
      i_isr_master.recv(1'b0, b);
      i_isr_master.stop();
      check({24'h0, b}, 32'hA5, "tx byte");
      check({31'h0, i_isr_master.stuck}, 32'h0, "clock released");
      $display("test tx done");
   endtask
   task automatic t_bcast();
      xfer(8'h00, 1'b0, 8'h00, 1'b0, "bcast refused");
      rdchk(OFF_STATUS, 32'h2, 32'h0, "no bcast event");
      bus(1'b1, OFF_BROADCAST_ACK_CONTROL, ALL);
      rdchk(OFF_BROADCAST_ACK_CONTROL, ALL, 32'h1, "bcast bit");
      xfer(8'h00, 1'b1, 8'h77, 1'b1, "bcast taken");
      rdchk(OFF_STATUS, 32'h2, 32'h2, "bcast seen");
      $display("test bcast done");
   endtask
   initial
   begin
      repeat (20) @(posedge ref_clk);
      rst <= 1'b0;
      repeat (5) @(posedge ref_clk);
      t_regs();
      t_freeze();
      t_rx();
      t_tx();
      t_bcast();
      finish_test();
   end
endmodule // testbench
`default_nettype wire
